// >>> logic/gpdpi_pkg.sv
// Purpose: Shared constants and carriers for the eight-pin port with pin interrupt
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Only byte lane 0 carries register bits
package gpdpi_pkg;
  // ****************************************
  // Sizes and offsets
  // ****************************************
  localparam int PIN_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EVT_W = 2;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_PULL = 8'h08;
  localparam logic [7:0] OFF_SLEW = 8'h0C;
  localparam logic [7:0] OFF_DRIVE = 8'h10;
  localparam logic [7:0] OFF_SC = 8'h14;
  localparam logic [7:0] OFF_PSEL = 8'h18;
  localparam logic [7:0] OFF_POL = 8'h1C;
  localparam logic [7:0] OFF_EVT_STS = 8'h20;
  localparam logic [7:0] OFF_EVT_MASK = 8'h24;
  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_SLEW = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam int SC_MODE_BIT = 0;
  localparam int SC_IE_BIT = 1;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_FLAG_BIT = 3;
  localparam int EVT_DETECT_BIT = 0;
  localparam int EVT_CHANGE_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } gpdpi_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } gpdpi_axi_rsp_t;
  typedef struct packed {
    logic [PIN_W-1:0] out;
    logic [PIN_W-1:0] oe;
    logic [PIN_W-1:0] pull_en;
    logic [PIN_W-1:0] pull_dn;
    logic [PIN_W-1:0] slew_en;
    logic [PIN_W-1:0] drive_hi;
  } gpdpi_pad_t;
  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] pin;
    logic [PIN_W-1:0] act_prev;
    logic [PIN_W-1:0] data;
    logic [PIN_W-1:0] dir;
    logic [PIN_W-1:0] pull;
    logic [PIN_W-1:0] slew;
    logic [PIN_W-1:0] drive;
    logic [PIN_W-1:0] psel;
    logic [PIN_W-1:0] pol;
    logic flag;
    logic ie;
    logic mode;
    logic [EVT_W-1:0] evt_sts;
    logic [EVT_W-1:0] evt_mask;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] waddr;
    logic [PIN_W-1:0] wdata;
    logic wlane0;
    gpdpi_axi_rsp_t rsp;
    gpdpi_pad_t pad;
    logic req;
    logic irq;
  } gpdpi_state_t;
endpackage

// >>> logic/gpdpi_port.sv
// Purpose: Eight-pin general purpose port with pin interrupt, AXI4-Lite slave
// Assumes: Pins arrive asynchronous to I_CORE_CLK
// Notes: Pad controls follow register writes one cycle late
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Function
// - Input pins read back their pin level
// - Output pins read back the written latch
// - Writes load all latches; outputs drive them
// - Reset clears latches, pins float, pulls off
// - Direction bit enables driver, selects readback
// - Pull enable bit switches pull device
// - Output pins never get a pull
// - Pull-down only on selected interrupt pins
// - Slew control acts only on outputs
// - Drive strength acts only on outputs
// - Flag bit set by detection, writes ignored
// - Acknowledge clears flag, reads as zero
// - Enable bit gates the interrupt request
// - Mode bit picks edges or edges+levels
// - Polarity bit picks pull and active sense
// - Source select bit includes pin as source
module gpdpi_port (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire gpdpi_pkg::gpdpi_axi_req_t I_AXI,
  input wire logic [gpdpi_pkg::PIN_W-1:0] I_PIN,
  output gpdpi_pkg::gpdpi_axi_rsp_t O_AXI,
  output gpdpi_pkg::gpdpi_pad_t O_PAD,
  output logic O_PIN_IRQ_REQ,
  output logic O_IRQ
);
  import gpdpi_pkg::*;

  gpdpi_state_t q;
  gpdpi_state_t d;

  // ****************************************
  // Pin sensing
  // ****************************************
  logic [PIN_W-1:0] pin_filt;
  logic [PIN_W-1:0] active;
  logic [PIN_W-1:0] edge_hit;
  logic [PIN_W-1:0] level_hit;
  logic set_evt;
  logic chg_evt;

  // A bit moves only once the last two stages agree
  assign pin_filt = (q.sync2 & q.sync3) | (q.pin & (q.sync2 ^ q.sync3));
  assign active = q.pol ^ ~q.pin;
  assign edge_hit = active & ~q.act_prev;
  assign level_hit = q.mode ? active : '0;
  assign set_evt = |(q.psel & ~q.dir & (edge_hit | level_hit));
  assign chg_evt = |(q.pin ^ pin_filt);

  // ****************************************
  // Bus decode
  // ****************************************
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic wr_en;
  logic ack_go;
  logic [ADDR_W-1:0] wr_word;
  logic [ADDR_W-1:0] rd_word_addr;
  logic [EVT_W-1:0] rd_clr;

  assign aw_hs = I_AXI.awvalid & q.rsp.awready;
  assign w_hs = I_AXI.wvalid & q.rsp.wready;
  assign ar_hs = I_AXI.arvalid & q.rsp.arready;
  assign wr_go = q.aw_held & q.w_held & ~q.rsp.bvalid;
  assign wr_en = wr_go & q.wlane0;
  assign wr_word = {q.waddr[ADDR_W-1:2], 2'h0};
  assign rd_word_addr = {I_AXI.araddr[ADDR_W-1:2], 2'h0};
  assign ack_go = wr_en & (wr_word == OFF_SC) & q.wdata[SC_ACK_BIT];
  // Reading the event status clears it
  assign rd_clr = {EVT_W{ar_hs & (rd_word_addr == OFF_EVT_STS)}};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [DATA_W-1:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic [EVT_W-1:0] evt_now;
    rd_word = '0;
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    evt_now = '0;
    d = q;
    d.sync1 = I_PIN;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.pin = pin_filt;
    d.act_prev = active;
    // Set beats acknowledge, so a held level survives it
    d.flag = set_evt | (q.flag & ~ack_go);
    evt_now[EVT_DETECT_BIT] = set_evt;
    evt_now[EVT_CHANGE_BIT] = chg_evt;
    d.evt_sts = evt_now | (q.evt_sts & ~rd_clr);

    if (aw_hs) begin
      d.aw_held = 1'b1;
      d.waddr = I_AXI.awaddr;
      d.rsp.awready = 1'b0;
    end
    if (w_hs) begin
      d.w_held = 1'b1;
      d.wdata = I_AXI.wdata[PIN_W-1:0];
      d.wlane0 = I_AXI.wstrb[0];
      d.rsp.wready = 1'b0;
    end
    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.rsp.bvalid = 1'b1;
      if (wr_word == OFF_DATA) begin
        if (q.wlane0) d.data = q.wdata;
      end else if (wr_word == OFF_DIR) begin
        if (q.wlane0) d.dir = q.wdata;
      end else if (wr_word == OFF_PULL) begin
        if (q.wlane0) d.pull = q.wdata;
      end else if (wr_word == OFF_SLEW) begin
        if (q.wlane0) d.slew = q.wdata;
      end else if (wr_word == OFF_DRIVE) begin
        if (q.wlane0) d.drive = q.wdata;
      end else if (wr_word == OFF_SC) begin
        if (q.wlane0) begin
          d.ie = q.wdata[SC_IE_BIT];
          d.mode = q.wdata[SC_MODE_BIT];
        end
      end else if (wr_word == OFF_PSEL) begin
        if (q.wlane0) d.psel = q.wdata;
      end else if (wr_word == OFF_POL) begin
        if (q.wlane0) d.pol = q.wdata;
      end else if (wr_word == OFF_EVT_MASK) begin
        if (q.wlane0) d.evt_mask = q.wdata[EVT_W-1:0];
      end else if (wr_word == OFF_EVT_STS) begin
        wr_hit = 1'b1;
      end else begin
        wr_hit = 1'b0;
      end
      d.rsp.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rsp.bvalid & I_AXI.bready) begin
      d.rsp.bvalid = 1'b0;
      d.rsp.awready = 1'b1;
      d.rsp.wready = 1'b1;
    end

    if (rd_word_addr == OFF_DATA) begin
      rd_word[PIN_W-1:0] = (q.dir & q.data) | (~q.dir & q.pin);
    end else if (rd_word_addr == OFF_DIR) begin
      rd_word[PIN_W-1:0] = q.dir;
    end else if (rd_word_addr == OFF_PULL) begin
      rd_word[PIN_W-1:0] = q.pull;
    end else if (rd_word_addr == OFF_SLEW) begin
      rd_word[PIN_W-1:0] = q.slew;
    end else if (rd_word_addr == OFF_DRIVE) begin
      rd_word[PIN_W-1:0] = q.drive;
    end else if (rd_word_addr == OFF_SC) begin
      rd_word[SC_FLAG_BIT] = q.flag;
      rd_word[SC_ACK_BIT] = 1'b0;
      rd_word[SC_IE_BIT] = q.ie;
      rd_word[SC_MODE_BIT] = q.mode;
    end else if (rd_word_addr == OFF_PSEL) begin
      rd_word[PIN_W-1:0] = q.psel;
    end else if (rd_word_addr == OFF_POL) begin
      rd_word[PIN_W-1:0] = q.pol;
    end else if (rd_word_addr == OFF_EVT_STS) begin
      rd_word[EVT_W-1:0] = q.evt_sts;
    end else if (rd_word_addr == OFF_EVT_MASK) begin
      rd_word[EVT_W-1:0] = q.evt_mask;
    end else begin
      rd_hit = 1'b0;
    end
    if (ar_hs) begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = rd_word;
      d.rsp.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rsp.rvalid & I_AXI.rready) begin
      d.rsp.rvalid = 1'b0;
      d.rsp.arready = 1'b1;
    end

    // Pad controls; inputs float unless pulled
    d.pad.out = q.data;
    d.pad.oe = q.dir;
    d.pad.pull_en = q.pull & ~q.dir;
    d.pad.pull_dn = q.pull & ~q.dir & q.psel & q.pol;
    d.pad.slew_en = q.slew & q.dir;
    d.pad.drive_hi = q.drive & q.dir;
    d.req = q.flag & q.ie;
    d.irq = |(q.evt_sts & q.evt_mask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      q <= '0;
      q.data <= RST_DATA;
      q.dir <= RST_DIR;
      q.pull <= RST_PULL;
      q.slew <= RST_SLEW;
      q.drive <= RST_DRIVE;
      // Pins reset low and low-active, so no false edge right after reset
      q.act_prev <= 8'hFF;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign O_AXI = q.rsp;
  assign O_PAD = q.pad;
  assign O_PIN_IRQ_REQ = q.req;
  assign O_IRQ = q.irq;

  // ****************************************
  // Checks
  // ****************************************
  property p_rd_input;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (ar_hs && rd_word_addr == OFF_DATA) |=>
      ((q.rsp.rdata[PIN_W-1:0] & ~$past(q.dir)) == ($past(q.pin) & ~$past(q.dir)));
  endproperty
  a_rd_input: assert property (p_rd_input) else $error("input pin readback wrong");

  property p_rd_output;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (ar_hs && rd_word_addr == OFF_DATA) |=>
      ((q.rsp.rdata[PIN_W-1:0] & $past(q.dir)) == ($past(q.data) & $past(q.dir)));
  endproperty
  a_rd_output: assert property (p_rd_output) else $error("output latch readback wrong");

  property p_data_write;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (wr_en && wr_word == OFF_DATA) |=> (q.data == $past(q.wdata)) ##1 (O_PAD.out == $past(q.data));
  endproperty
  a_data_write: assert property (p_data_write) else $error("latch write not driven");

  property p_oe_dir;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (O_PAD.oe == $past(q.dir));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("driver enable not from direction");

  property p_pull;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (O_PAD.pull_en == ($past(q.pull) & ~$past(q.dir)));
  endproperty
  a_pull: assert property (p_pull) else $error("pull enable wrong");

  property p_pull_dn;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 ((O_PAD.pull_dn & ~($past(q.psel) & $past(q.pol) & O_PAD.pull_en)) == '0);
  endproperty
  a_pull_dn: assert property (p_pull_dn) else $error("pull-down on non-interrupt pin");

  property p_slew_drive;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 ((O_PAD.slew_en | O_PAD.drive_hi) & ~$past(q.dir)) == '0;
  endproperty
  a_slew_drive: assert property (p_slew_drive) else $error("slew or drive on input");

  property p_flag_cause;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    $rose(q.flag) |-> $past(set_evt);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without detection");

  property p_ack_reads_zero;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (ar_hs && rd_word_addr == OFF_SC) |=> !q.rsp.rdata[SC_ACK_BIT];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("acknowledge bit read as one");

  property p_req_gate;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (O_PIN_IRQ_REQ == ($past(q.flag) && $past(q.ie)));
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request not gated by enable");

  property p_edge_only;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (!q.mode && $stable(q.pin) && $stable(q.pol)) |-> !set_evt;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("level sensed in edge mode");

  property p_level_hold;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (ack_go && q.mode && ((q.psel & ~q.dir & active) != '0)) |=> q.flag;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("flag lost with level held");

  property p_out_pad;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (O_PAD.out == $past(q.data));
  endproperty
  a_out_pad: assert property (p_out_pad) else $error("pad level not from latch");

  property p_slew_pad;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (O_PAD.slew_en == ($past(q.slew) & $past(q.dir)));
  endproperty
  a_slew_pad: assert property (p_slew_pad) else $error("slew control not applied to output");

  property p_drive_pad;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (O_PAD.drive_hi == ($past(q.drive) & $past(q.dir)));
  endproperty
  a_drive_pad: assert property (p_drive_pad) else $error("drive select not applied to output");

  property p_flag_hold;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (q.flag && !ack_go) |=> q.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without acknowledge");

  property p_rd_flag;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (ar_hs && rd_word_addr == OFF_SC) |=> (q.rsp.rdata[SC_FLAG_BIT] == $past(q.flag));
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("flag readback wrong");

  property p_ack_clear;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (ack_go && !set_evt) |=> !q.flag;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear flag");

  property p_req_off;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 ($past(q.ie) || !O_PIN_IRQ_REQ);
  endproperty
  a_req_off: assert property (p_req_off) else $error("request raised while disabled");

  property p_level_set;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (q.mode && ((q.psel & ~q.dir & active) != '0)) |=> q.flag;
  endproperty
  a_level_set: assert property (p_level_set) else $error("held level not flagged");

  property p_pull_pol;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 ((O_PAD.pull_dn & ~$past(q.pol)) == '0);
  endproperty
  a_pull_pol: assert property (p_pull_pol) else $error("pull-down with low polarity");

  property p_sel_only;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (((q.psel & ~q.dir) == '0) && !q.flag) |=> !q.flag;
  endproperty
  a_sel_only: assert property (p_sel_only) else $error("flag set with no source selected");

  property p_filter;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (((q.pin ^ $past(q.pin)) & ($past(q.sync2) ^ $past(q.sync3))) == '0);
  endproperty
  a_filter: assert property (p_filter) else $error("pin moved before stages agreed");

  property p_filter_take;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ##1 (((q.pin ^ $past(q.sync2)) & ~($past(q.sync2) ^ $past(q.sync3))) == '0);
  endproperty
  a_filter_take: assert property (p_filter_take) else $error("agreed pin level not taken");
endmodule

// >>> verification/gpdpi_pins.sv
// Purpose: Far-side model of the eight port pins and board drivers
// Assumes: Pad controls from the port, bench-driven external levels
// Notes: An undriven, unpulled pin toggles every cycle instead of holding
`timescale 1ns/1ps
module gpdpi_pins (
  input wire logic i_clk,
  input wire gpdpi_pkg::gpdpi_pad_t i_pad,
  input wire logic [gpdpi_pkg::PIN_W-1:0] i_ext_en,
  input wire logic [gpdpi_pkg::PIN_W-1:0] i_ext_val,
  output logic [gpdpi_pkg::PIN_W-1:0] o_pin
);
  import gpdpi_pkg::*;
  // ****************************************
  // Wire resolution
  // ****************************************
  // Floating pins must not read as a stable level
  logic [PIN_W-1:0] float_q = 8'h55;
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (i_pad.oe[i]) begin
        o_pin[i] = i_pad.out[i];
      end else if (i_ext_en[i]) begin
        o_pin[i] = i_ext_val[i];
      end else if (i_pad.pull_en[i]) begin
        o_pin[i] = ~i_pad.pull_dn[i];
      end else begin
        o_pin[i] = float_q[i];
      end
    end
  end
endmodule

// >>> verification/test_gpio_port_d_with_pin_interrupt.sv
// Purpose: Self-checking bench for the eight-pin port with pin interrupt
// Assumes: AXI4-Lite master in the bench, pin model on the far side
// Notes: Pin changes need several cycles to pass the input filter
`timescale 1ns/1ps
module test_gpio_port_d_with_pin_interrupt;
  import gpdpi_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  gpdpi_axi_req_t req = '0;
  gpdpi_axi_rsp_t rsp;
  gpdpi_pad_t pad;
  logic [7:0] pin;
  logic irq_req;
  logic irq;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] ext_val = 8'h00;
  int err_total = 0;
  int checks_done = 0;
  gpdpi_port DUT (.I_CORE_CLK(clk), .I_NRST(nrst), .I_AXI(req), .I_PIN(pin), .O_AXI(rsp), .O_PAD(pad),
    .O_PIN_IRQ_REQ(irq_req), .O_IRQ(irq));
  gpdpi_pins pins (.i_clk(clk), .i_pad(pad), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));
  initial begin
    forever #2 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results();
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    err_total++;
    results();
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 50);
    req.bready <= 1'b0;
    if (n >= 50) hang();
    check(8'(rsp.bresp), 8'(er));
    // Next call must not re-drive bready in this same step
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 50);
    req.rready <= 1'b0;
    if (n >= 50) hang();
    check(rsp.rdata[7:0], ed);
    check(8'(rsp.rresp), 8'(er));
    @(posedge clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check(8'(|pad), 8'h00);
    for (int a = 0; a <= 36; a += 4) rd(8'(a), 8'h00, RESP_OKAY);
    wr(OFF_SLEW, 8'h00, RESP_OKAY);
    rd(8'h30, 8'h00, RESP_SLVERR);
    wr(8'h30, 8'h5A, RESP_SLVERR);
  endtask
  task automatic t_data_pads();
    ext_val <= 8'h3C;
    wr(OFF_DIR, 8'h0F, RESP_OKAY);
    wr(OFF_DATA, 8'hA5, RESP_OKAY);
    wt(8);
    rd(OFF_DATA, 8'h35, RESP_OKAY);
    check(pad.out, 8'hA5);
    check(pad.oe, 8'h0F);
    wr(OFF_PULL, 8'hFF, RESP_OKAY);
    wr(OFF_PSEL, 8'hF0, RESP_OKAY);
    wr(OFF_POL, 8'h30, RESP_OKAY);
    wr(OFF_SLEW, 8'hFF, RESP_OKAY);
    wr(OFF_DRIVE, 8'hFF, RESP_OKAY);
    ext_en <= 8'h00;
    wt(8);
    check(pad.pull_en, 8'hF0);
    check(pad.pull_dn, 8'h30);
    check(pad.slew_en, 8'h0F);
    check(pad.drive_hi, 8'h0F);
    rd(OFF_DATA, 8'hC5, RESP_OKAY);
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    wr(OFF_DIR, 8'h00, RESP_OKAY);
  endtask
  task automatic t_edge();
    int n = 0;
    wr(OFF_PSEL, 8'h10, RESP_OKAY);
    wr(OFF_POL, 8'h10, RESP_OKAY);
    wr(OFF_EVT_MASK, 8'h01, RESP_OKAY);
    // Pad scenario left a flag and events pending
    wr(OFF_SC, 8'h06, RESP_OKAY);
    wt(10);
    rd(OFF_EVT_STS, 8'h03, RESP_OKAY);
    rd(OFF_EVT_STS, 8'h00, RESP_OKAY);
    rd(OFF_SC, 8'h02, RESP_OKAY);
    check(8'(irq_req), 8'h00);
    ext_val <= 8'h10;
    while (irq_req !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    if (n >= 30) hang();
    rd(OFF_SC, 8'h0A, RESP_OKAY);
    wt(2);
    check(8'(irq), 8'h01);
    rd(OFF_EVT_STS, 8'h03, RESP_OKAY);
    wt(3);
    check(8'(irq), 8'h00);
    wr(OFF_SC, 8'h02, RESP_OKAY);
    rd(OFF_SC, 8'h0A, RESP_OKAY);
    wr(OFF_SC, 8'h08, RESP_OKAY);
    wt(3);
    check(8'(irq_req), 8'h00);
    wr(OFF_SC, 8'h06, RESP_OKAY);
    rd(OFF_SC, 8'h02, RESP_OKAY);
  endtask
  task automatic t_level();
    wr(OFF_SC, 8'h03, RESP_OKAY);
    wt(5);
    rd(OFF_SC, 8'h0B, RESP_OKAY);
    wr(OFF_SC, 8'h07, RESP_OKAY);
    rd(OFF_SC, 8'h0B, RESP_OKAY);
    ext_val <= 8'h00;
    wt(10);
    wr(OFF_SC, 8'h07, RESP_OKAY);
    rd(OFF_SC, 8'h03, RESP_OKAY);
    wr(OFF_PSEL, 8'h00, RESP_OKAY);
    ext_val <= 8'h10;
    wt(10);
    rd(OFF_SC, 8'h03, RESP_OKAY);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    wt(12);
    nrst <= 1'b1;
    wt(6);
    t_reset();
    t_data_pads();
    t_edge();
    t_level();
    results();
  end
endmodule
